// *** logic/adcsr_pkg.sv ***
// Constants and types for the converter readout and power-down control.
// =====================================================================
// Summary of operation
// - Power-down needs the shift clock held high for twenty conversion periods.
// - After four high cycles: short low pulse, then high, modulator reset.
// - Sixteen further high periods after detection enter power-down.
// - Shift clock falling releases power-down; first ready after 2318.5 clocks.
// - After the first ready pulse, pulses continue at normal cadence.
// - Each result is 24 bits, most significant bit first.
// - Results are two's complement; negative full scale is hex 800000.
// - Per cycle: write 6 clocks, low 6, high 6, then data output.
// - Pin held high 24 clocks before each ready phase.
// - Hold-detection low pulse lasts 3 system clocks.
// - Synchronization starts 1537 to 7679 clocks after the hold begins.
// - Power-down starts no sooner than 7681 clocks after the hold begins.
// - Power-down starts about 6144.5 clocks after the last ready pulse.
// - Sync release: ready phase about 2042.5 clocks after shift clock falls.
// - Channel change holds the pin high about 2043.5 clocks.
// - Bits change on shift clock falling; host captures on rising.
// - No clocks: MSB stays; partial read: last bit; over 24: low.
// - Bit pointer resets at write start and pre-ready high start.
// - Load, pulse low, high, then data; negative result keeps pin high.
package adcsr_pkg;

   // ==================================================================
   // Conversion cycle phasing, in system clock periods
   localparam int CONV_CLKS      = 384;
   localparam int T_WRITE_CLKS   = 6;
   localparam int T_LOW_CLKS     = 6;
   localparam int T_HIGH_CLKS    = 6;
   localparam int T_PRE_CLKS     = 24;
   localparam int PH_LOW_START   = T_WRITE_CLKS;
   localparam int PH_HIGH_START  = PH_LOW_START + T_LOW_CLKS;
   localparam int PH_DOUT_START  = PH_HIGH_START + T_HIGH_CLKS;
   localparam int PH_PRE_START   = CONV_CLKS - T_PRE_CLKS;
   localparam int RESULT_BITS    = 24;

   // ==================================================================
   // Hold detection, in conversion periods, and pulse width in clocks
   localparam int HOLD_DETECT    = 4;
   localparam int HOLD_PDOWN     = 16;
   localparam int PULSE_CLKS     = 3;

   // ==================================================================
   // Release delays in tenths of a system clock period, then cycles
   localparam int T_SYNC_REL_X10 = 20425;
   localparam int T_PD_REL_X10   = 23185;
   localparam int T_MUX_X10      = 20435;
   localparam int SYNC_REL_CLKS  = T_SYNC_REL_X10 / 10;
   localparam int PD_REL_CLKS    = T_PD_REL_X10 / 10;
   localparam int MUX_CLKS       = T_MUX_X10 / 10;

   // ==================================================================
   // Operating modes of the control logic
   typedef enum logic [1:0] {
      MODE_RUN   = 2'b00,
      MODE_HOLD  = 2'b01,
      MODE_PDOWN = 2'b10,
      MODE_WAKE  = 2'b11
   } adcsr_mode_type;

   // Whole register state of the control block.
   typedef struct packed {
      adcsr_mode_type mode;
      logic [8:0]     phase;
      logic [4:0]     hold_cnt;
      logic           hi_all;
      logic [11:0]    wait_cnt;
      logic [1:0]     pulse_cnt;
      logic [23:0]    shreg;
      logic [4:0]     bit_cnt;
      logic           sclk_prev;
      logic [1:0]     chan_prev;
      logic           pin;
      logic           mod_rst;
      logic           pdown;
   } adcsr_state_type;

   // Synchronised pin inputs travelling together.
   typedef struct packed {
      logic       sclk;
      logic [1:0] chan;
   } adcsr_pins_type;

endpackage

// *** logic/adcsr_sync.sv ***
// Two flip-flop synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
module adcsr_sync #(
   parameter int W = 3
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // Data
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } adcsr_sync_type;

   adcsr_sync_type s_q;
   adcsr_sync_type s_d;

   // =================================================================
   // The first stage feeds only the second stage.
   always_comb begin
      s_d.meta = i_d;
      s_d.q    = s_q.meta;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_q = s_q.q;

endmodule

// *** logic/adcsr_ctrl.sv ***
// Conversion phasing, serial result readout and power-down control.
`timescale 1ns/1ps
module adcsr_ctrl (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Host pins
   input  wire logic        i_shift_clock,
   input  wire logic        i_channel_select_0,
   input  wire logic        i_channel_select_1,
   output logic             o_ready_data_out,
   // Converter core
   input  wire logic [23:0] i_result,
   output logic             o_modulator_reset,
   output logic             o_power_down
);

   adcsr_pkg::adcsr_state_type s_q;
   adcsr_pkg::adcsr_state_type s_d;
   adcsr_pkg::adcsr_pins_type  pins;
   logic                       sclk_fall;
   logic                       dout_phase;

   // =================================================================
   // Pin synchronisation
   adcsr_sync #(
      .W (3)
   ) u_sync (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_d   ({i_shift_clock, i_channel_select_1, i_channel_select_0}),
      .o_q   (pins)
   );

   // Shift clock falling edge as seen on our clock.
   assign sclk_fall  = s_q.sclk_prev & ~pins.sclk;
   assign dout_phase = (s_q.phase >= 9'(adcsr_pkg::PH_DOUT_START)) &&
                       (s_q.phase <  9'(adcsr_pkg::PH_PRE_START));

   // =================================================================
   // Next-state logic
   always_comb begin
      s_d           = s_q;
      s_d.sclk_prev = pins.sclk;
      s_d.chan_prev = pins.chan;
      unique case (s_q.mode)
         adcsr_pkg::MODE_RUN: begin
            s_d.mod_rst = 1'b0;
            s_d.pdown   = 1'b0;
            s_d.hi_all  = s_q.hi_all & pins.sclk;
            if (s_q.phase == 9'(adcsr_pkg::CONV_CLKS - 1)) begin
               s_d.phase  = '0;
               s_d.hi_all = 1'b1;
               if (s_q.hi_all && pins.sclk) begin
                  s_d.hold_cnt = s_q.hold_cnt + 5'h01;
               end else begin
                  s_d.hold_cnt = '0;
               end
            end else begin
               s_d.phase = s_q.phase + 9'h001;
            end
            if (s_q.phase == 9'h000) begin
               s_d.shreg   = i_result; // two's complement passes as is.
               s_d.bit_cnt = '0;
            end
            if (s_q.phase == 9'(adcsr_pkg::PH_PRE_START)) begin
               s_d.bit_cnt = '0;
            end
            if (dout_phase && sclk_fall) begin
               s_d.shreg = {s_q.shreg[22:0], 1'b0};
               if (s_q.bit_cnt != 5'(adcsr_pkg::RESULT_BITS)) begin
                  s_d.bit_cnt = s_q.bit_cnt + 5'h01;
               end
            end
            // pin phases; data from the top bit
            if (s_q.phase < 9'(adcsr_pkg::PH_LOW_START)) begin
               s_d.pin = 1'b1;
            end else if (s_q.phase < 9'(adcsr_pkg::PH_HIGH_START)) begin
               s_d.pin = 1'b0;
            end else if (s_q.phase < 9'(adcsr_pkg::PH_DOUT_START)) begin
               s_d.pin = 1'b1;
            end else if (dout_phase) begin
               s_d.pin = s_d.shreg[23];
            end else begin
               s_d.pin = 1'b1; // high before ready.
            end
            if (s_d.hold_cnt == 5'(adcsr_pkg::HOLD_DETECT)) begin
               s_d.mode      = adcsr_pkg::MODE_HOLD;
               s_d.hold_cnt  = '0;
               s_d.pin       = 1'b0;
               s_d.pulse_cnt = 2'(adcsr_pkg::PULSE_CLKS - 1);
               s_d.mod_rst   = 1'b1;
            end else if (pins.chan != s_q.chan_prev) begin
               s_d.mode     = adcsr_pkg::MODE_WAKE;
               s_d.wait_cnt = 12'(adcsr_pkg::MUX_CLKS);
               s_d.pin      = 1'b1;
            end
         end
         adcsr_pkg::MODE_HOLD: begin
            s_d.pin = (s_q.pulse_cnt == 2'h0);
            if (s_q.pulse_cnt != 2'h0) begin
               s_d.pulse_cnt = s_q.pulse_cnt - 2'h1;
            end
            s_d.phase = (s_q.phase == 9'(adcsr_pkg::CONV_CLKS - 1)) ?
                        9'h000 : s_q.phase + 9'h001;
            if (sclk_fall) begin
               s_d.mode     = adcsr_pkg::MODE_WAKE;
               s_d.wait_cnt = 12'(adcsr_pkg::SYNC_REL_CLKS);
               s_d.mod_rst  = 1'b0;
               s_d.pin      = 1'b1; // A cut pulse must not linger low.
            end else if (s_q.phase == 9'(adcsr_pkg::CONV_CLKS - 1)) begin
               s_d.hold_cnt = s_q.hold_cnt + 5'h01;
               if (s_d.hold_cnt == 5'(adcsr_pkg::HOLD_PDOWN)) begin
                  s_d.mode  = adcsr_pkg::MODE_PDOWN;
                  s_d.pdown = 1'b1;
               end
            end
         end
         adcsr_pkg::MODE_PDOWN: begin
            s_d.pin = 1'b1;
            if (sclk_fall) begin
               s_d.mode     = adcsr_pkg::MODE_WAKE;
               s_d.wait_cnt = 12'(adcsr_pkg::PD_REL_CLKS);
               s_d.pdown    = 1'b0;
               s_d.mod_rst  = 1'b0;
            end
         end
         adcsr_pkg::MODE_WAKE: begin
            s_d.pin      = 1'b1;
            s_d.wait_cnt = s_q.wait_cnt - 12'h001;
            // resume cadence at the ready phase
            if (s_q.wait_cnt == 12'h001) begin
               s_d.mode     = adcsr_pkg::MODE_RUN;
               // The pin goes low on this edge already, so the phase
               // starts at the second low clock to keep the pulse at six.
               s_d.phase    = 9'(adcsr_pkg::PH_LOW_START + 1);
               s_d.shreg    = i_result;
               s_d.bit_cnt  = '0;
               s_d.hold_cnt = '0;
               s_d.hi_all   = 1'b1;
               s_d.pin      = 1'b0;
            end
         end
      endcase
   end

   // =================================================================
   // State register; pin idles high as the pre-ready level.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q        <= '0;
         s_q.hi_all <= 1'b1;
         s_q.pin    <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_ready_data_out  = s_q.pin;
   assign o_modulator_reset = s_q.mod_rst;
   assign o_power_down      = s_q.pdown;

   // =================================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_ready_low;
      ($fell(o_ready_data_out) && s_q.mode == adcsr_pkg::MODE_RUN &&
       s_q.phase == 9'(adcsr_pkg::PH_LOW_START + 1))
         |-> (!o_ready_data_out)[*6] ##1 o_ready_data_out;
   endproperty
   a_ready_low: assert property (p_ready_low)
      else $error("Ready low pulse is not six clocks.");

   property p_hold_pulse;
      $rose(s_q.mode == adcsr_pkg::MODE_HOLD)
         |-> (!o_ready_data_out)[*3] ##1 o_ready_data_out;
   endproperty
   a_hold_pulse: assert property (p_hold_pulse)
      else $error("Hold pulse is not three clocks.");

   property p_hold_reset;
      (s_q.mode == adcsr_pkg::MODE_HOLD) |-> o_modulator_reset;
   endproperty
   a_hold_reset: assert property (p_hold_reset)
      else $error("Modulator not in reset during hold.");

   property p_pdown_entry;
      $rose(o_power_down) |-> $past(s_q.mode) == adcsr_pkg::MODE_HOLD;
   endproperty
   a_pdown_entry: assert property (p_pdown_entry)
      else $error("Power-down entered without a hold.");

   property p_wake_high;
      $rose(s_q.mode == adcsr_pkg::MODE_WAKE)
         |-> o_ready_data_out[*8];
   endproperty
   a_wake_high: assert property (p_wake_high)
      else $error("Pin not high after release.");

   property p_overread_low;
      (s_q.mode == adcsr_pkg::MODE_RUN && dout_phase &&
       pins.chan == s_q.chan_prev &&
       s_q.phase != 9'(adcsr_pkg::PH_PRE_START - 1) &&
       s_q.bit_cnt == 5'(adcsr_pkg::RESULT_BITS))
         |=> !o_ready_data_out;
   endproperty
   a_overread_low: assert property (p_overread_low)
      else $error("Pin not low after a full read.");

   property p_pre_high;
      (s_q.mode == adcsr_pkg::MODE_RUN &&
       s_q.phase == 9'(adcsr_pkg::PH_PRE_START))
         |=> o_ready_data_out[*8];
   endproperty
   a_pre_high: assert property (p_pre_high)
      else $error("Pin not high before ready.");

   property p_ptr_reset;
      (s_q.mode == adcsr_pkg::MODE_RUN && s_q.phase == 9'h000)
         |=> s_q.bit_cnt == 5'h00;
   endproperty
   a_ptr_reset: assert property (p_ptr_reset)
      else $error("Bit pointer not reset at write.");

endmodule

// *** bench/adcsr_host_model.sv ***
// Host model that drives the shift clock and reads result bits.
`timescale 1ns/1ps
module adcsr_host_model (
   // Clock
   input  wire logic i_clk,
   // Converter pins
   input  wire logic i_ready_data_out,
   output logic      o_shift_clock
);
   // ==================================================================
   // Shift clock control
   // The shift clock rests low between frames, as a real host leaves it.
   initial o_shift_clock = 1'b0;

   // hold for power-down
   // A long high level is how the host asks for a hold or power-down.
   task automatic set_level(input logic v);
      @(negedge i_clk);
      o_shift_clock = v;
   endtask

   // read on rise
   // A bit is taken as the clock rises; the converter moves on at the
   // fall. Half period is four system clocks, so 320 ns a bit.
   task automatic read_bits(input int n, output logic [24:0] w);
      w = '0;
      for (int i = 0; i < n; i++) begin
         @(negedge i_clk);
         o_shift_clock = 1'b1;
         w = {w[23:0], i_ready_data_out};
         repeat (4) @(negedge i_clk);
         o_shift_clock = 1'b0;
         repeat (3) @(negedge i_clk);
      end
   endtask
endmodule

// *** bench/adcsr_ctrl_tb.sv ***
// Self-checking bench for converter readout and power-down control.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      checked++; \
      if ((g) !== (e)) begin \
         error_cnt++; \
         $display("ERROR %s expected %0h seen %0h", nm, e, g); \
      end \
   end
module adcsr_ctrl_tb;
   // ==================================================================
   // Clock, reset and pins
   logic        i_clk     = 1'b0;
   logic        i_rst     = 1'b1;
   logic [1:0]  chan      = 2'b00;
   logic [23:0] result    = 24'h800000;
   logic        sclk;
   logic        pin;
   logic        mod_rst;
   logic        pdown;
   int          error_cnt = 0;
   int          checked   = 0;
   logic [23:0] vals [4]  = '{24'h800000, 24'h7FFFFF, 24'h000000,
                              24'hA5C35A};

   // A 40 ns period gives the 25 MHz system clock.
   always #20 i_clk = ~i_clk;

   adcsr_ctrl dut (.i_clk(i_clk), .i_rst(i_rst), .i_shift_clock(sclk),
      .i_channel_select_0(chan[0]), .i_channel_select_1(chan[1]),
      .o_ready_data_out(pin), .i_result(result),
      .o_modulator_reset(mod_rst), .o_power_down(pdown));

   adcsr_host_model host (.i_clk(i_clk), .i_ready_data_out(pin),
      .o_shift_clock(sclk));

   // ==================================================================
   // Helpers
   // Counts falling clock edges until the pin shows v, bounded by lim.
   task automatic wait_lvl(input logic v, input int lim, output int n);
      n = 0;
      while (pin !== v && n < lim) begin
         @(negedge i_clk);
         n++;
      end
   endtask

   // Waits for a ready pulse: the first low after a long high. A word
   // with a zero top bit gives a long low in the data phase, so a plain
   // high-to-low edge is not enough to find the pulse.
   task automatic wait_ready;
      int n;
      int hi;
      hi = 0;
      while (hi < adcsr_pkg::T_PRE_CLKS) begin
         wait_lvl(1'b1, 800, n);
         wait_lvl(1'b0, 800, hi);
      end
   endtask

   task automatic close_out;
      $display("Checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ==================================================================
   // Readout: phasing, coding, bit order and over-read.
   // Two pulses are skipped so the checked word is surely the new one.
   task automatic t_read(input logic [23:0] res);
      int          n;
      logic [24:0] w;
      logic [2:0]  top;
      result = res;
      repeat (2) wait_ready();
      wait_lvl(1'b1, 20, n);
      `CHK("low_len", 6, n)
      repeat (32) @(negedge i_clk);
      `CHK("msb_hold", res[23], pin)
      // A partial read must leave the last shifted bit on the pin.
      host.read_bits(3, w);
      top = w[2:0];
      `CHK("partial_hold", res[20], pin)
      host.read_bits(22, w);
      `CHK("word", res, {top, w[21:1]})
      `CHK("over_read", 1'b0, w[0])
      wait_lvl(1'b1, 400, n);
      wait_lvl(1'b0, 40, n);
      `CHK("pre_high", 30, n)
      $display("Test read %h done", res);
   endtask

   // ==================================================================
   // Channel change in mid data phase; every select code is used.
   task automatic t_chan;
      int n;
      result = 24'h800000;
      for (int c = 1; c <= 4; c++) begin
         wait_lvl(1'b1, 800, n);
         wait_lvl(1'b0, 800, n);
         wait_lvl(1'b1, 20, n);
         repeat (40) @(negedge i_clk);
         chan = 2'(c);
         wait_lvl(1'b0, 2200, n);
         `CHK("mux_hold", 1'b1, (n >= 2043 && n <= 2050))
      end
      $display("Test channel change done");
   endtask

   // ==================================================================
   // Shift clock hold, short (sync only) or long (power-down), release.
   // A negative result keeps the pin high so only pulses show as lows.
   task automatic t_hold(input int len, input logic pd);
      int n;
      int run    = 0;
      int last   = 0;
      int t_mr   = 0;
      int t_pd   = 0;
      int t_fall = 0;
      int lows   = 0;
      result = 24'h800000;
      host.set_level(1'b1);
      for (int k = 1; k <= len; k++) begin
         @(negedge i_clk);
         if (pin === 1'b0) begin
            run++;
         end else if (run > 0) begin
            last = run;
            t_fall = k - run;
            run = 0;
         end
         if (mod_rst === 1'b1 && t_mr == 0) t_mr = k;
         if (t_mr > 0 && k > t_mr + 5 && pin === 1'b0) lows++;
         if (pdown === 1'b1 && t_pd == 0) t_pd = k;
      end
      `CHK("sync_start", 1'b1, (t_mr >= 1537 && t_mr <= 7679))
      `CHK("sync_pulse", 3, last)
      `CHK("held_high", 0, lows)
      `CHK("pdown", pd, pdown)
      if (pd) begin
         `CHK("pd_start", 1'b1, t_pd >= 7681)
         `CHK("pd_gap", 1'b1, (t_pd - t_fall >= 6140 && t_pd - t_fall <= 6150))
      end
      host.set_level(1'b0);
      wait_lvl(1'b0, 2400, n);
      `CHK("release", 1'b1, pd ? (n >= 2318 && n <= 2325) : (n >= 2042 && n <= 2049))
      `CHK("pdown_off", 1'b0, pdown)
      `CHK("mr_off", 1'b0, mod_rst)
      wait_lvl(1'b1, 20, n);
      `CHK("wake_low", 6, n)
      wait_lvl(1'b0, 400, n);
      `CHK("cadence", 378, n)
      $display("Test hold %0d done", len);
   endtask

   // ==================================================================
   // Main sequence
   initial begin
      repeat (2) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (3) @(negedge i_clk);
      foreach (vals[i]) t_read(vals[i]);
      t_chan();
      t_hold(3072, 1'b0);
      t_hold(8832, 1'b1);
      close_out();
   end

   // The tests need about 31600 clocks; this limit leaves ample margin.
   initial begin
      #(80000 * 40);
      error_cnt++;
      close_out();
   end
endmodule
